/* verilog/card_regs_pkg.sv */
// card_regs_pkg: offsets, field positions, reset values and carrier types
// for the card configuration and status register bank.
// assumes byte accesses at even attribute-memory addresses.
package card_regs_pkg;

  // ----------------------------------------------------------------
  // register offsets from the configuration base
  // ----------------------------------------------------------------
  localparam logic [10:0] OFF_CARD_STATUS = 11'h002; // card_status_control
  localparam logic [10:0] OFF_PIN_REPL = 11'h004; // pin_replacement
  localparam logic [10:0] OFF_SOCKET_COPY = 11'h006; // socket_and_copy
  localparam logic [10:0] OFF_IO_BASE_LOW = 11'h00A; // io_window_base_low
  localparam logic [10:0] OFF_IO_BASE_HIGH = 11'h00C; // io_window_base_high
  localparam logic [10:0] OFF_IO_LIMIT = 11'h012; // io_window_limit
  localparam logic [10:0] OFF_BASE_STEP = 11'h002; // spacing of base bytes

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CS_CHANGED = 7; // change summary
  localparam int CS_SIG_EN = 6; // status_change_enable
  localparam int CS_BYTE_IO = 5; // byte_io_select
  localparam int CS_PL1_DIS = 4; // power_level1_disable
  localparam int CS_AUDIO = 3; // audio enable
  localparam int CS_PWR_DOWN = 2; // power_down_request
  localparam int CS_INT = 1; // interrupt mirror
  localparam int PR_READY_CHG = 5; // ready_change_latch
  localparam int PR_WG_CHG = 4; // write_guard_change_latch
  localparam int PR_ONES_HI = 3; // reads as one
  localparam int PR_ONES_LO = 2; // reads as one
  localparam int PR_READY_LVL = 1; // ready mirror / ready_change_mask
  localparam int PR_WG_LVL = 0; // write_guard_level / write_guard_change_mask
  localparam int SC_DRIVE = 4; // drive number

  // ----------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] MASK_ONE_BYTE = 16'h00FF;
  localparam logic [15:0] MASK_TWO_BYTES = 16'hFFFF;
  localparam logic [10:0] CFG_BASE_DEFAULT = 11'h200;
  localparam logic [5:0] CFG_INDEX_MEMORY = 6'h00; // memory-mapped mode

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic reg_n; // attribute space select, low active
    logic ce1_n; // even byte enable, low active
    logic oe_n; // read strobe, low active
    logic we_n; // write strobe, low active
    logic [10:0] addr; // byte address
    logic [7:0] data; // even byte data
  } attr_bus_type;

  typedef struct packed {
    logic hit; // access falls in the window
    logic [7:0] offset; // port offset within the window
  } io_decode_type;

endpackage

/* verilog/card_config_status_registers.sv */
// card_config_status_registers: card status, pin replacement, socket/copy
// and I/O window base/limit registers behind attribute-memory byte cycles.
// assumes the host pins are asynchronous to clk_i and held stable for
// several clocks per cycle; core-side inputs are on clk_i.
//
// Contract
// - change summary is OR of change latches
// - status line low when summary and enable in I/O mode
// - byte I/O select ignored on storage profile
// - level-1 disable bit readable, resets zero
// - storage profile: level-1 disable reads zero
// - speaker passes audio only when enabled
// - power-down bit requests saving or active mode
// - ready busy until requested power state reached
// - storage profile idles down, wakes on command
// - interrupt bit mirrors request, gated by enable
// - ready level change sets ready latch
// - write guard change sets guard latch
// - pin register mirrors internal ready level
// - write guard level always reads zero
// - change latch written only under mask
// - drive number held, socket bits ignored
// - base registers little-endian, low byte first
// - base register count follows decoded lines
// - limit bits mark decoded address lines
// - limit only with base, else fixed
// - zero configuration index ignores I/O cycles
`timescale 1ns/10ps
`default_nettype none

module card_config_status_registers #(
  parameter bit STORAGE_PROFILE = 1'b0, // 1: storage card, 0: I/O card
  parameter int BASE_REGS = 2, // implemented base bytes, 1 or 2
  parameter bit LIMIT_PRESENT = 1'b1, // limit register implemented
  parameter logic [7:0] FIXED_LIMIT = 8'h07, // window size when no limit register
  parameter logic [10:0] CFG_BASE = card_regs_pkg::CFG_BASE_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire card_regs_pkg::attr_bus_type attr_i, // host attribute pins, raw
  output logic [7:0] data_o, // read data toward the host
  output logic data_oe_o, // high while driving the data pins
  input wire logic [5:0] configuration_index_i, // from option register
  input wire logic ready_level_i, // internal ready state
  input wire logic write_guard_raw_level_i, // guard level, tie low without switch
  input wire logic irq_request_i, // internal interrupt request
  input wire logic device_irq_enable_n_i, // device-control interrupt disable
  input wire logic audio_i, // audio from the function
  input wire logic power_state_i, // 1 once power-saving entered, 0 when active
  input wire logic idle_i, // storage core idle
  input wire logic command_i, // storage core received a command
  input wire logic [15:0] io_addr_i, // I/O cycle address
  output logic status_change_line_n_o, // status-change pin, low active
  output logic speaker_out_o, // gated audio
  output logic ready_o, // ready pin, low while busy
  output logic byte_io_select_o, // 8-bit I/O mode selected
  output logic power_level1_disable_o, // level-1 commands disabled
  output logic power_down_o, // power-saving request to the core
  output card_regs_pkg::io_decode_type io_decode_o // registered window decode
);
  import card_regs_pkg::*;
  default clocking @(posedge clk_i); endclocking // assertions sample on clk_i
  default disable iff (rst_i); // assertions rest while reset is high
  // ----------------------------------------------------------------
  // pin synchroniser and strobe detection
  // ----------------------------------------------------------------
  attr_bus_type sync1; // first stage, read only by sync2
  attr_bus_type sync2; // second stage
  attr_bus_type sync3; // previous sample, for edges
  // two-flop synchroniser, then one more stage for edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= '{reg_n: 1'b1, ce1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
      sync2 <= '{reg_n: 1'b1, ce1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
      sync3 <= '{reg_n: 1'b1, ce1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
    end else begin
      sync1 <= attr_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // address match against one register of the bank
  function automatic logic reg_hit(input logic [10:0] addr, input logic [10:0] off);
    reg_hit = (addr == CFG_BASE + off);
  endfunction
  logic attr_sel; // attribute byte cycle selected
  logic wr_stb; // one-cycle pulse at the end of a write
  logic rd_cycle; // read in progress
  logic [10:0] wr_addr; // address of the completed write
  logic [7:0] wr_data; // data of the completed write
  assign attr_sel = !sync3.reg_n && !sync3.ce1_n;
  // a write takes effect as the write strobe rises
  assign wr_stb = attr_sel && !sync3.we_n && sync2.we_n;
  assign wr_addr = sync3.addr;
  assign wr_data = sync3.data;
  assign rd_cycle = !sync2.reg_n && !sync2.ce1_n && !sync2.oe_n && sync2.we_n;

  // ----------------------------------------------------------------
  // card status and control register
  // ----------------------------------------------------------------
  logic status_change_enable; // change signalling enable
  logic byte_io_select; // 8-bit I/O request
  logic power_level1_disable; // level-1 disable
  logic audio_enable; // speaker gate
  logic power_down_request; // power-saving request
  logic power_down_prev; // request one cycle ago
  logic ready_busy; // power transition in progress
  logic changed; // change summary
  logic int_pending; // interrupt mirror
  logic io_configured; // nonzero configuration index
  logic wr_status; // write to status register
  assign wr_status = wr_stb && reg_hit(wr_addr, OFF_CARD_STATUS);
  assign io_configured = (configuration_index_i != CFG_INDEX_MEMORY);
  // host-written control bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_change_enable <= 1'b0;
      byte_io_select <= 1'b0;
      power_level1_disable <= 1'b0;
      audio_enable <= 1'b0;
      power_down_request <= 1'b0;
    end else if (wr_status) begin
      status_change_enable <= wr_data[CS_SIG_EN];
      byte_io_select <= STORAGE_PROFILE ? 1'b0 : wr_data[CS_BYTE_IO];
      power_level1_disable <= STORAGE_PROFILE ? 1'b0 : wr_data[CS_PL1_DIS];
      audio_enable <= wr_data[CS_AUDIO];
      power_down_request <= wr_data[CS_PWR_DOWN];
    end
  end
  // busy from any change of the request until the core reports the state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_down_prev <= 1'b0;
      ready_busy <= 1'b0;
    end else begin
      power_down_prev <= power_down_request;
      if (power_down_request != power_down_prev) begin
        ready_busy <= 1'b1;
      end else if (power_state_i == power_down_request) begin
        ready_busy <= 1'b0;
      end
    end
  end
  // storage card drops power when idle, commands win over idle
  assign power_down_o = power_down_request || (STORAGE_PROFILE && idle_i && !command_i);
  assign int_pending = irq_request_i && !device_irq_enable_n_i;

  // ----------------------------------------------------------------
  // pin replacement register
  // ----------------------------------------------------------------
  logic ready_change_latch; // ready level changed
  logic write_guard_change_latch; // guard level changed
  logic ready_level_prev; // last ready level
  logic write_guard_prev; // last guard level
  logic wr_pin; // write to pin replacement
  assign wr_pin = wr_stb && reg_hit(wr_addr, OFF_PIN_REPL);
  assign changed = ready_change_latch || write_guard_change_latch;
  // edge history of the watched levels; reset to their idle levels so
  // that leaving reset is not mistaken for a change
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_level_prev <= 1'b1;
      write_guard_prev <= 1'b0;
    end else begin
      ready_level_prev <= ready_level_i;
      write_guard_prev <= write_guard_raw_level_i;
    end
  end
  // change latches: a change in the write cycle beats a masked clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_change_latch <= 1'b0;
      write_guard_change_latch <= 1'b0;
    end else begin
      if (ready_level_i != ready_level_prev) begin
        ready_change_latch <= 1'b1;
      end else if (wr_pin && wr_data[PR_READY_LVL]) begin
        ready_change_latch <= wr_data[PR_READY_CHG];
      end
      if (write_guard_raw_level_i != write_guard_prev) begin
        write_guard_change_latch <= 1'b1;
      end else if (wr_pin && wr_data[PR_WG_LVL]) begin
        write_guard_change_latch <= wr_data[PR_WG_CHG];
      end
    end
  end

  // ----------------------------------------------------------------
  // socket and copy register
  // ----------------------------------------------------------------
  logic drive_number; // twin-card drive number
  // only the drive number is kept; socket number and reserved bit dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_number <= 1'b0;
    end else if (wr_stb && reg_hit(wr_addr, OFF_SOCKET_COPY)) begin
      drive_number <= wr_data[SC_DRIVE];
    end
  end

  // ----------------------------------------------------------------
  // I/O window base and limit
  // ----------------------------------------------------------------
  logic [7:0] io_base [2]; // index 0 is the low address byte
  logic [7:0] io_limit; // marked low address lines
  logic [15:0] decode_mask; // lines the function decodes
  // one base byte per decoded address byte, the rest stay zero
  for (genvar gi = 0; gi < 2; gi++) begin : g_base
    if (gi < BASE_REGS) begin : g_impl
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          io_base[gi] <= BYTE_ZERO;
        end else if (wr_stb && reg_hit(wr_addr, OFF_IO_BASE_LOW + OFF_BASE_STEP * 11'(gi))) begin
          io_base[gi] <= wr_data;
        end
      end
    end else begin : g_absent
      assign io_base[gi] = BYTE_ZERO;
    end
  end
  if (LIMIT_PRESENT) begin : g_limit
    // host keeps the set bits contiguous from bit 0
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        io_limit <= FIXED_LIMIT;
      end else if (wr_stb && reg_hit(wr_addr, OFF_IO_LIMIT)) begin
        io_limit <= wr_data;
      end
    end
  end else begin : g_fixed
    assign io_limit = FIXED_LIMIT;
  end
  assign decode_mask = (BASE_REGS > 1) ? MASK_TWO_BYTES : MASK_ONE_BYTE;
  // window decode, registered toward the function
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_decode_o <= '0;
    end else begin
      io_decode_o.hit <= io_configured &&
        (((io_addr_i ^ {io_base[1], io_base[0]}) & decode_mask & ~{BYTE_ZERO, io_limit}) == '0);
      io_decode_o.offset <= io_addr_i[7:0] & io_limit;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] next_data; // read value for the addressed register
  logic addr_mapped; // address belongs to the bank
  // read mux; unmapped addresses leave the pins undriven
  always_comb begin
    next_data = BYTE_ZERO;
    addr_mapped = 1'b1;
    if (reg_hit(sync2.addr, OFF_CARD_STATUS)) begin
      next_data[CS_CHANGED] = changed;
      next_data[CS_SIG_EN] = status_change_enable;
      next_data[CS_BYTE_IO] = byte_io_select;
      next_data[CS_PL1_DIS] = power_level1_disable;
      next_data[CS_AUDIO] = audio_enable;
      next_data[CS_PWR_DOWN] = power_down_request;
      next_data[CS_INT] = int_pending;
    end else if (reg_hit(sync2.addr, OFF_PIN_REPL)) begin
      next_data[PR_READY_CHG] = ready_change_latch;
      next_data[PR_WG_CHG] = write_guard_change_latch;
      next_data[PR_ONES_HI] = 1'b1;
      next_data[PR_ONES_LO] = 1'b1;
      next_data[PR_READY_LVL] = ready_level_i;
      next_data[PR_WG_LVL] = 1'b0;
    end else if (reg_hit(sync2.addr, OFF_SOCKET_COPY)) begin
      next_data[SC_DRIVE] = drive_number;
    end else if (reg_hit(sync2.addr, OFF_IO_BASE_LOW)) begin
      next_data = io_base[0];
    end else if (reg_hit(sync2.addr, OFF_IO_BASE_HIGH)) begin
      next_data = io_base[1];
    end else if (reg_hit(sync2.addr, OFF_IO_LIMIT)) begin
      next_data = io_limit;
    end else begin
      addr_mapped = 1'b0;
    end
  end
  // registered read data and enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= BYTE_ZERO;
      data_oe_o <= 1'b0;
    end else begin
      data_o <= next_data;
      data_oe_o <= rd_cycle && addr_mapped;
    end
  end

  // ----------------------------------------------------------------
  // pin-facing outputs
  // ----------------------------------------------------------------
  // status-change pin, high unless signalling in I/O mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_change_line_n_o <= 1'b1;
      speaker_out_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      status_change_line_n_o <= !(io_configured && changed && status_change_enable);
      speaker_out_o <= io_configured && audio_enable && audio_i;
      ready_o <= ready_level_i && !ready_busy;
    end
  end
  assign byte_io_select_o = byte_io_select;
  assign power_level1_disable_o = power_level1_disable;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_req_flip;
    power_down_request != power_down_prev;
  endsequence
  sequence s_busy_held;
    ready_busy ##1 !ready_o;
  endsequence

  property p_changed_read;
    reg_hit(sync2.addr, OFF_CARD_STATUS) |=> data_o[CS_CHANGED] == $past(changed);
  endproperty
  a_changed_read: assert property (p_changed_read) else $error("change summary misread");
  property p_status_line;
    (io_configured && changed && status_change_enable) |=> !status_change_line_n_o;
  endproperty
  a_status_line: assert property (p_status_line) else $error("status line not low");
  property p_pl1_storage;
    STORAGE_PROFILE |-> !power_level1_disable_o && !byte_io_select_o;
  endproperty
  a_pl1_storage: assert property (p_pl1_storage) else $error("storage bit not zero");
  property p_speaker;
    !audio_enable |=> !speaker_out_o;
  endproperty
  a_speaker: assert property (p_speaker) else $error("audio leaked");
  property p_busy;
    s_req_flip |=> s_busy_held;
  endproperty
  a_busy: assert property (p_busy) else $error("ready not busy");
  property p_int_gate;
    reg_hit(sync2.addr, OFF_CARD_STATUS) && device_irq_enable_n_i |=> !data_o[CS_INT];
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("int bit not gated");
  property p_ready_change;
    $changed(ready_level_i) |=> ready_change_latch ##1 (ready_change_latch || $past(wr_pin));
  endproperty
  a_ready_change: assert property (p_ready_change) else $error("ready change missed");
  property p_mask_hold;
    (wr_pin && !wr_data[PR_READY_LVL] && ready_level_i == ready_level_prev) |=> $stable(ready_change_latch);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("masked latch moved");
  property p_guard_zero;
    reg_hit(sync2.addr, OFF_PIN_REPL) |=> !data_o[PR_WG_LVL] && data_o[PR_ONES_HI];
  endproperty
  a_guard_zero: assert property (p_guard_zero) else $error("guard level not zero");
  property p_memory_mode;
    !io_configured |=> !io_decode_o.hit;
  endproperty
  a_memory_mode: assert property (p_memory_mode) else $error("io hit in memory mode");

endmodule

`default_nettype wire

/* sim/host_attr_model.sv */
// host_attr_model: host socket side, byte cycles on the attribute pins.
// assumes clk_i is the card clock; pins change just after rising edges.
`timescale 1ns/10ps
`default_nettype none

module host_attr_model (
  input wire logic clk_i,
  output var card_regs_pkg::attr_bus_type attr_o,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i
);
  import card_regs_pkg::*;

  // ------------------------------------------------------------
  // idle pins: strobes high, released data never repeats a value
  // ------------------------------------------------------------
  initial begin
    attr_o = '{1'b1, 1'b1, 1'b1, 1'b1, 11'h000, 8'h00};
  end

  // ------------------------------------------------------------
  // byte write: every phase held five clocks, well above the sync lag
  // ------------------------------------------------------------
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_i);
    attr_o <= '{1'b0, 1'b0, 1'b1, 1'b0, a, d};
    repeat (5) @(posedge clk_i);
    attr_o.we_n <= 1'b1; // write commits on this rise
    repeat (5) @(posedge clk_i);
    attr_o <= '{1'b1, 1'b1, 1'b1, 1'b1, a, ~d};
    repeat (5) @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // byte read: data taken at the edge before the strobes rise
  // ------------------------------------------------------------
  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk_i);
    attr_o <= '{1'b0, 1'b0, 1'b0, 1'b1, a, ~attr_o.data};
    repeat (5) @(posedge clk_i);
    d = data_i;
    oe = data_oe_i;
    attr_o <= '{1'b1, 1'b1, 1'b1, 1'b1, a, ~attr_o.data};
    repeat (5) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

/* sim/card_config_status_registers_test.sv */
// card_config_status_registers_test: register cycles and core levels,
// compared against read-back values and the pin outputs.
// assumes host_attr_model supplies the wr and rd byte-cycle tasks.
`timescale 1ns/10ps
`default_nettype none

module card_config_status_registers_test;
  import card_regs_pkg::*;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam logic [10:0] cfg_base = CFG_BASE_DEFAULT;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  attr_bus_type attr;
  logic [7:0] data;
  logic data_oe;
  logic [5:0] cfg_index = 6'h00; // unconfigured until socket written
  logic ready_level = 1'b1;
  logic guard_level = 1'b0;
  logic irq_req = 1'b0;
  logic irq_dis_n = 1'b0;
  logic audio = 1'b1;
  logic power_state = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic status_line_n, speaker, ready, byte_io, pl1_dis, power_down;
  io_decode_type io_dec;
  logic idle = 1'b0; // storage core idle
  logic command = 1'b0; // storage core command seen
  logic st_byte_io, st_pl1_dis, st_power_down; // storage twin outputs
  int miscompares = 0;
  int checks_done = 0;

  always #5 clk_i = ~clk_i; // 100 MHz

  host_attr_model u_host (.clk_i(clk_i), .attr_o(attr), .data_i(data), .data_oe_i(data_oe));

  card_config_status_registers u_dut (.clk_i(clk_i), .rst_i(rst_i), .attr_i(attr), .data_o(data),
    .data_oe_o(data_oe), .configuration_index_i(cfg_index), .ready_level_i(ready_level),
    .write_guard_raw_level_i(guard_level), .irq_request_i(irq_req), .device_irq_enable_n_i(irq_dis_n),
    .audio_i(audio), .power_state_i(power_state), .idle_i(idle), .command_i(command),
    .io_addr_i(io_addr), .status_change_line_n_o(status_line_n), .speaker_out_o(speaker),
    .ready_o(ready), .byte_io_select_o(byte_io), .power_level1_disable_o(pl1_dis),
    .power_down_o(power_down), .io_decode_o(io_dec));

  // storage-profile twin on the same pins; only its profile-dependent outputs are watched
  card_config_status_registers #(.STORAGE_PROFILE(1'b1)) u_dut_storage (.clk_i(clk_i), .rst_i(rst_i),
    .attr_i(attr), .data_o(), .data_oe_o(), .configuration_index_i(cfg_index), .ready_level_i(ready_level),
    .write_guard_raw_level_i(guard_level), .irq_request_i(irq_req), .device_irq_enable_n_i(irq_dis_n),
    .audio_i(audio), .power_state_i(power_state), .idle_i(idle), .command_i(command),
    .io_addr_i(io_addr), .status_change_line_n_o(), .speaker_out_o(), .ready_o(),
    .byte_io_select_o(st_byte_io), .power_level1_disable_o(st_pl1_dis), .power_down_o(st_power_down),
    .io_decode_o());

  // ------------------------------------------------------------
  // verdict, comparisons and bounded waits
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    check8(name, {7'h00, exp}, {7'h00, got});
  endtask

  // read a register and compare both enable and data
  task automatic rd_chk(input logic [10:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    u_host.rd(a, d, oe);
    check1("data_oe_o", 1'b1, oe);
    check8("data_o", exp, d);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ready must return once the core reports the requested state
  task automatic wait_ready();
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_i);
      if (ready === 1'b1) begin
        return;
      end
    end
    miscompares++;
    $display("MISMATCH ready_o expected 1 seen timeout");
    final_report();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic oe;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(cfg_base + OFF_CARD_STATUS, 8'h00);
    rd_chk(cfg_base + OFF_PIN_REPL, 8'h0E);
    u_host.wr(cfg_base + OFF_SOCKET_COPY, 8'h1F);
    rd_chk(cfg_base + OFF_SOCKET_COPY, 8'h10);
    cfg_index <= 6'h01;
    settle(3);
    check1("speaker_out_o", 1'b0, speaker);
    u_host.wr(cfg_base + OFF_CARD_STATUS, 8'h38);
    rd_chk(cfg_base + OFF_CARD_STATUS, 8'h38);
    check1("byte_io_select_o", 1'b1, byte_io);
    check1("power_level1_disable_o", 1'b1, pl1_dis);
    check1("speaker_out_o", 1'b1, speaker);
    check1("u_dut_storage.byte_io_select_o", 1'b0, st_byte_io);
    check1("u_dut_storage.power_level1_disable_o", 1'b0, st_pl1_dis);
    idle <= 1'b1;
    settle(2);
    check1("power_down_o", 1'b0, power_down);
    check1("u_dut_storage.power_down_o", 1'b1, st_power_down);
    command <= 1'b1;
    settle(2);
    check1("u_dut_storage.power_down_o", 1'b0, st_power_down);
    idle <= 1'b0;
    command <= 1'b0;
    u_host.wr(cfg_base + OFF_CARD_STATUS, 8'h3C);
    check1("power_down_o", 1'b1, power_down);
    check1("ready_o", 1'b0, ready);
    power_state <= 1'b1;
    wait_ready();
    ready_level <= 1'b0;
    settle(3);
    rd_chk(cfg_base + OFF_PIN_REPL, 8'h2C);
    rd_chk(cfg_base + OFF_CARD_STATUS, 8'hBC);
    check1("status_change_line_n_o", 1'b1, status_line_n);
    u_host.wr(cfg_base + OFF_CARD_STATUS, 8'h7C);
    check1("status_change_line_n_o", 1'b0, status_line_n);
    u_host.wr(cfg_base + OFF_PIN_REPL, 8'h00);
    rd_chk(cfg_base + OFF_PIN_REPL, 8'h2C);
    u_host.wr(cfg_base + OFF_PIN_REPL, 8'h02);
    rd_chk(cfg_base + OFF_PIN_REPL, 8'h0C);
    check1("status_change_line_n_o", 1'b1, status_line_n);
    guard_level <= 1'b1;
    settle(3);
    rd_chk(cfg_base + OFF_PIN_REPL, 8'h1C);
    guard_level <= 1'b0;
    settle(3);
    u_host.wr(cfg_base + OFF_PIN_REPL, 8'h01);
    rd_chk(cfg_base + OFF_PIN_REPL, 8'h0C);
    irq_req <= 1'b1;
    settle(3);
    rd_chk(cfg_base + OFF_CARD_STATUS, 8'h7E);
    irq_dis_n <= 1'b1;
    settle(3);
    rd_chk(cfg_base + OFF_CARD_STATUS, 8'h7C);
    u_host.wr(cfg_base + OFF_IO_BASE_LOW, 8'h40);
    u_host.wr(cfg_base + OFF_IO_BASE_HIGH, 8'h03);
    u_host.wr(cfg_base + OFF_IO_LIMIT, 8'h07);
    rd_chk(cfg_base + OFF_IO_BASE_LOW, 8'h40);
    rd_chk(cfg_base + OFF_IO_BASE_HIGH, 8'h03);
    rd_chk(cfg_base + OFF_IO_LIMIT, 8'h07);
    io_addr <= 16'h0345;
    settle(3);
    check1("io_decode_o.hit", 1'b1, io_dec.hit);
    check8("io_decode_o.offset", 8'h05, io_dec.offset);
    io_addr <= 16'h0385;
    settle(3);
    check1("io_decode_o.hit", 1'b0, io_dec.hit);
    io_addr <= 16'h0345;
    cfg_index <= 6'h00;
    settle(3);
    check1("io_decode_o.hit", 1'b0, io_dec.hit);
    check1("speaker_out_o", 1'b0, speaker);
    // unmapped place: the card must leave the data pins alone
    u_host.rd(cfg_base + 11'h008, d, oe);
    check1("data_oe_o", 1'b0, oe);
    final_report();
  end
endmodule

`default_nettype wire
